// >>> verilog/hes_pkg.sv
// Constants, register map and carrier types for hot-plug event signalling
`default_nettype none
package hes_pkg;
  localparam int NP = 5;
  localparam int EVT_W = 5;
  localparam int EVT_BTN = 0;
  localparam int EVT_PWR = 1;
  localparam int EVT_LATCH = 2;
  localparam int EVT_PRES = 3;
  localparam int EVT_CMD = 4;
  localparam logic [EVT_W-1:0] WAKE_SRC_MASK = 5'h0F;
  localparam logic [EVT_W-1:0] INIT_SUPPRESS = 5'h0C;
  localparam int PORT_SEL_LSB = 4;
  localparam logic [3:0] OFF_SLOT_CTL = 4'h0;
  localparam logic [3:0] OFF_SLOT_STS = 4'h4;
  localparam logic [3:0] OFF_PORT_CFG = 4'h8;
  localparam logic [7:0] OFF_GPE_CTL = 8'h80;
  localparam logic [7:0] OFF_GPE_STS = 8'h84;
  localparam logic [7:0] OFF_GPIO_CFG = 8'h88;
  localparam logic [7:0] OFF_IRQ_STS = 8'h8C;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h90;
  localparam int GPIO_ALT = 0;
  localparam int GPIO_LVL = 1;
  localparam int GPIO_OE = 2;
  typedef struct packed {
    logic irq_en;
    logic [EVT_W-1:0] mask;
  } hes_slot_ctl_t;
  typedef struct packed {
    logic d3hot;
    logic intx_dis;
    logic msi_en;
  } hes_port_cfg_t;
  typedef struct packed {
    logic msi;
    logic pme;
    logic intx;
    logic gpe;
  } hes_msg_t;
  localparam hes_slot_ctl_t SCTL_RST = '0;
  localparam hes_port_cfg_t PCFG_RST = '0;
  localparam logic [NP-1:0] GPE_CTL_RST = 5'h00;
  localparam logic [2:0] GPIO_CFG_RST = 3'h0;
  localparam logic [NP-1:0] IRQ_MSK_RST = 5'h00;
endpackage
`default_nettype wire

// >>> verilog/hes_sticky.sv
// Sticky flag vector, write-one-to-clear, set beats clear
`default_nettype none
module hes_sticky #(
  parameter int W = 1
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] q_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      q_q <= '0;
    end else begin
      q_q <= (q_q & ~clr_i) | set_i; // see R17
    end
  end

  assign q_o = q_q;

  property p_set_wins;
    @(posedge core_clk_i) disable iff (rst_i)
      (set_i != '0) |=> ((q_o & $past(set_i)) == $past(set_i));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("sticky flag lost its set"); // see R17

  property p_clear_ones;
    @(posedge core_clk_i) disable iff (rst_i)
      (set_i == '0) |=> ((q_o & $past(clr_i)) == '0);
  endproperty
  a_clear_ones: assert property (p_clear_ones) else $error("sticky flag not cleared"); // see R17
endmodule // hes_sticky
`default_nettype wire

// >>> verilog/hes_port.sv
// Per-port qualification of slot events into messages
`default_nettype none
module hes_port
  import hes_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [EVT_W-1:0] flags_i,
  input wire hes_slot_ctl_t ctl_i,
  input wire hes_port_cfg_t cfg_i,
  input wire logic sw_d3hot_i,
  input wire logic gpe_mode_i,
  input wire logic other_msi_i,
  input wire logic other_pme_i,
  input wire logic other_intx_i,
  output hes_msg_t msg_o
);
  logic [EVT_W-1:0] live;
  logic q_irq;
  logic q_wake;
  logic irq_q;
  logic wake_q;
  logic irq_rise;
  logic wake_rise;
  hes_msg_t msg_q;

  assign live = flags_i & ~ctl_i.mask; // see R2, R6
  assign q_irq = (|live) & ctl_i.irq_en; // see R1
  // Command completion never wakes
  assign q_wake = (|(live & WAKE_SRC_MASK)) & (cfg_i.d3hot | sw_d3hot_i); // see R4, R5, R7
  // Edge of the level condition: a held flag raises one message only
  assign irq_rise = q_irq & ~irq_q; // see R17
  assign wake_rise = q_wake & ~wake_q; // see R17

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q <= q_irq;
      wake_q <= q_wake;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      msg_q <= '0;
    end else begin
      msg_q.msi <= (irq_rise & cfg_i.msi_en & ~gpe_mode_i) | other_msi_i; // see R3, R8, R14
      msg_q.pme <= (wake_rise & ~gpe_mode_i) | other_pme_i; // see R4, R5, R8, R14
      msg_q.intx <= (q_irq & ~cfg_i.msi_en & ~cfg_i.intx_dis & ~gpe_mode_i) | other_intx_i; // see R3, R8, R14
      msg_q.gpe <= (irq_rise | wake_rise) & gpe_mode_i; // see R9
    end
  end

  assign msg_o = msg_q;

  property p_irq_needs_en;
    @(posedge core_clk_i) disable iff (rst_i)
      (msg_o.msi && !$past(other_msi_i)) |-> $past(ctl_i.irq_en);
  endproperty
  a_irq_needs_en: assert property (p_irq_needs_en) else $error("msi without slot irq enable"); // see R1

  property p_mask_blocks;
    @(posedge core_clk_i) disable iff (rst_i)
      ((msg_o.pme && !$past(other_pme_i)) || (msg_o.msi && !$past(other_msi_i))) |-> $past(|live);
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("message from masked event"); // see R6

  property p_route;
    @(posedge core_clk_i) disable iff (rst_i)
      (msg_o.intx && !$past(other_intx_i)) |-> $past(!cfg_i.msi_en && !cfg_i.intx_dis && q_irq);
  endproperty
  a_route: assert property (p_route) else $error("intx asserted against routing"); // see R3

  property p_wake_d3;
    @(posedge core_clk_i) disable iff (rst_i)
      (msg_o.pme && !$past(other_pme_i)) |-> $past((cfg_i.d3hot || sw_d3hot_i) && !gpe_mode_i);
  endproperty
  a_wake_d3: assert property (p_wake_d3) else $error("wake outside d3hot"); // see R4

  property p_both_in_d3;
    @(posedge core_clk_i) disable iff (rst_i)
      (irq_rise && wake_rise && cfg_i.msi_en && !gpe_mode_i) |=> (msg_o.msi && msg_o.pme);
  endproperty
  a_both_in_d3: assert property (p_both_in_d3) else $error("d3hot event missing msi or wake"); // see R5

  property p_cmd_no_wake;
    @(posedge core_clk_i) disable iff (rst_i)
      (msg_o.pme && !$past(other_pme_i)) |-> $past(|(live & WAKE_SRC_MASK));
  endproperty
  a_cmd_no_wake: assert property (p_cmd_no_wake) else $error("wake from command completion"); // see R7

  property p_gpe_silences;
    @(posedge core_clk_i) disable iff (rst_i)
      $past(gpe_mode_i && !other_msi_i && !other_pme_i && !other_intx_i) |-> !(msg_o.msi || msg_o.pme || msg_o.intx);
  endproperty
  a_gpe_silences: assert property (p_gpe_silences) else $error("pcie message in gpe mode"); // see R8

  property p_other_pass;
    @(posedge core_clk_i) disable iff (rst_i)
      other_intx_i |=> msg_o.intx;
  endproperty
  a_other_pass: assert property (p_other_pass) else $error("other intx source suppressed"); // see R14
endmodule // hes_port
`default_nettype wire

// >>> verilog/hes_top.sv
// Hot-plug event signalling for the downstream ports, with APB registers
// Behaviour
// R1 - Hot-plug interrupts only with slot irq enable
// R2 - Five status flags request interrupt unless masked
// R3 - MSI enable and legacy disable pick message
// R4 - D3hot, irq enable off: wake only
// R5 - D3hot, irq enable on: wake and interrupt
// R6 - Masked event gives neither wake nor interrupt
// R7 - Command completion never causes a wake
// R8 - GPE mode silences hot-plug INTx, MSI, PME
// R9 - GPE mode reports events on shared output
// R10 - GPIO 7 follows output only in alternate
// R11 - Signalled GPE event sets port status bit
// R12 - GPE status bit settable only in GPE mode
// R13 - Slot flags and masks unchanged in GPE mode
// R14 - Other-source messages pass in GPE mode
// R15 - No presence or latch flags during init
// R16 - Shared output high while any status set
// R17 - Flags cleared by ones; level-like requests
//
// The APB slave port and the placing of the registers are this design's own decisions.
`default_nettype none
module hes_top
  import hes_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [NP-1:0][EVT_W-1:0] slot_evt_i,
  input wire logic [NP-1:0] init_access_i,
  input wire logic sw_d3hot_i,
  input wire logic [NP-1:0] other_msi_i,
  input wire logic [NP-1:0] other_pme_i,
  input wire logic [NP-1:0] other_intx_i,
  output logic [NP-1:0] msi_req_o,
  output logic [NP-1:0] pme_req_o,
  output logic [NP-1:0] intx_o,
  output logic gp_event_out_o,
  output logic gpio7_o,
  output logic gpio7_oe_o,
  output logic irq_o
);
  hes_slot_ctl_t slot_ctl_q [NP];
  hes_port_cfg_t port_cfg_q [NP];
  logic [EVT_W-1:0] slot_sts [NP];
  hes_msg_t msg [NP];
  logic [NP-1:0] gpe_ctl_q;
  logic [NP-1:0] gpe_sts;
  logic [NP-1:0] gpe_evt;
  logic [NP-1:0] gpe_clr;
  logic [NP-1:0] irq_sts;
  logic [NP-1:0] irq_set;
  logic [NP-1:0] irq_clr;
  logic [NP-1:0] irq_msk_q;
  logic [2:0] gpio_cfg_q;
  logic gpio7_q;
  logic gpio7_oe_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic hit;
  logic setup;
  logic acc;
  logic wr_acc;
  logic [2:0] pidx;
  logic port_hit;

  // APB decode; address must stay stable through the access phase
  assign setup = psel_i & ~penable_i;
  assign acc = psel_i & penable_i;
  assign wr_acc = acc & pwrite_i;
  assign pidx = paddr_i[PORT_SEL_LSB+2:PORT_SEL_LSB];
  assign port_hit = ~paddr_i[7] & (pidx < NP);

  always_comb begin
    rd_d = '0;
    hit = 1'b0;
    if (port_hit) begin
      case (paddr_i[3:0])
        OFF_SLOT_CTL: begin
          hit = 1'b1;
          rd_d = 32'(slot_ctl_q[pidx]);
        end
        OFF_SLOT_STS: begin
          hit = 1'b1;
          rd_d = 32'(slot_sts[pidx]);
        end
        OFF_PORT_CFG: begin
          hit = 1'b1;
          rd_d = 32'(port_cfg_q[pidx]);
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end else begin
      case (paddr_i)
        OFF_GPE_CTL: begin
          hit = 1'b1;
          rd_d = 32'(gpe_ctl_q);
        end
        OFF_GPE_STS: begin
          hit = 1'b1;
          rd_d = 32'(gpe_sts);
        end
        OFF_GPIO_CFG: begin
          hit = 1'b1;
          rd_d = 32'(gpio_cfg_q);
        end
        OFF_IRQ_STS: begin
          hit = 1'b1;
          rd_d = 32'(irq_sts);
        end
        OFF_IRQ_MSK: begin
          hit = 1'b1;
          rd_d = 32'(irq_msk_q);
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end
  end

  // Read data caught in setup so that prdata comes from a flop
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      prdata_q <= '0;
    end else if (setup) begin
      prdata_q <= rd_d;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = acc;
  assign pslverr_o = acc & ~hit;

  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_port
      logic sel;
      logic [EVT_W-1:0] sts_set;
      logic [EVT_W-1:0] sts_clr;

      assign sel = wr_acc & port_hit & (pidx == 3'(p));

      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          slot_ctl_q[p] <= SCTL_RST;
          port_cfg_q[p] <= PCFG_RST;
        end else begin
          if (sel && (paddr_i[3:0] == OFF_SLOT_CTL)) begin
            slot_ctl_q[p] <= hes_slot_ctl_t'(pwdata_i[$bits(hes_slot_ctl_t)-1:0]);
          end
          if (sel && (paddr_i[3:0] == OFF_PORT_CFG)) begin
            port_cfg_q[p] <= hes_port_cfg_t'(pwdata_i[$bits(hes_port_cfg_t)-1:0]);
          end
        end
      end

      // Status flags behave the same whatever the notification mode
      assign sts_set = slot_evt_i[p] & ~(init_access_i[p] ? INIT_SUPPRESS : '0); // see R13, R15
      assign sts_clr = (sel && (paddr_i[3:0] == OFF_SLOT_STS)) ? pwdata_i[EVT_W-1:0] : '0; // see R17

      hes_sticky #(
        .W(EVT_W)
      ) u_slot_sts (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .set_i(sts_set),
        .clr_i(sts_clr),
        .q_o(slot_sts[p])
      );

      hes_port u_port (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .flags_i(slot_sts[p]),
        .ctl_i(slot_ctl_q[p]),
        .cfg_i(port_cfg_q[p]),
        .sw_d3hot_i(sw_d3hot_i),
        .gpe_mode_i(gpe_ctl_q[p]),
        .other_msi_i(other_msi_i[p]),
        .other_pme_i(other_pme_i[p]),
        .other_intx_i(other_intx_i[p]),
        .msg_o(msg[p])
      );

      assign msi_req_o[p] = msg[p].msi;
      assign pme_req_o[p] = msg[p].pme;
      assign intx_o[p] = msg[p].intx;
      assign gpe_evt[p] = msg[p].gpe;
      assign irq_set[p] = msg[p].msi | msg[p].pme | msg[p].gpe;

      property p_init_quiet;
        @(posedge core_clk_i) disable iff (rst_i)
          (init_access_i[p] && ((slot_sts[p] & INIT_SUPPRESS) == '0)) |=> ((slot_sts[p] & INIT_SUPPRESS) == '0);
      endproperty
      a_init_quiet: assert property (p_init_quiet) else $error("presence or latch flag set during init"); // see R15
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gpe_ctl_q <= GPE_CTL_RST;
    end else if (wr_acc && (paddr_i == OFF_GPE_CTL)) begin
      gpe_ctl_q <= pwdata_i[NP-1:0];
    end
  end

  assign gpe_clr = (wr_acc && (paddr_i == OFF_GPE_STS)) ? pwdata_i[NP-1:0] : '0;

  // Event pulse only leaves a port in GPE mode; the gate keeps it so
  hes_sticky #(
    .W(NP)
  ) u_gpe_sts (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .set_i(gpe_evt & gpe_ctl_q), // see R11, R12
    .clr_i(gpe_clr),
    .q_o(gpe_sts)
  );

  assign gp_event_out_o = |gpe_sts; // see R9, R16

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gpio_cfg_q <= GPIO_CFG_RST;
    end else if (wr_acc && (paddr_i == OFF_GPIO_CFG)) begin
      gpio_cfg_q <= pwdata_i[2:0];
    end
  end

  // Pin is driven in alternate mode even if the plain enable is off
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gpio7_q <= 1'b0;
      gpio7_oe_q <= 1'b0;
    end else begin
      gpio7_q <= gpio_cfg_q[GPIO_ALT] ? gp_event_out_o : gpio_cfg_q[GPIO_LVL]; // see R10
      gpio7_oe_q <= gpio_cfg_q[GPIO_ALT] | gpio_cfg_q[GPIO_OE]; // see R10
    end
  end

  assign gpio7_o = gpio7_q;
  assign gpio7_oe_o = gpio7_oe_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_msk_q <= IRQ_MSK_RST;
    end else if (wr_acc && (paddr_i == OFF_IRQ_MSK)) begin
      irq_msk_q <= pwdata_i[NP-1:0];
    end
  end

  assign irq_clr = (wr_acc && (paddr_i == OFF_IRQ_STS)) ? pwdata_i[NP-1:0] : '0;

  hes_sticky #(
    .W(NP)
  ) u_irq_sts (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .set_i(irq_set),
    .clr_i(irq_clr),
    .q_o(irq_sts)
  );

  assign irq_o = |(irq_sts & irq_msk_q);

  property p_gpe_reported;
    @(posedge core_clk_i) disable iff (rst_i)
      ((gpe_evt & gpe_ctl_q) != '0) |=> ##[0:1] gp_event_out_o;
  endproperty
  a_gpe_reported: assert property (p_gpe_reported) else $error("gpe event not on shared output"); // see R9

  property p_gpe_sts_set;
    @(posedge core_clk_i) disable iff (rst_i)
      ((gpe_evt & gpe_ctl_q) != '0) |=> ((gpe_sts & $past(gpe_evt & gpe_ctl_q)) == $past(gpe_evt & gpe_ctl_q));
  endproperty
  a_gpe_sts_set: assert property (p_gpe_sts_set) else $error("gpe status bit not set"); // see R11

  property p_gpe_sts_mode;
    @(posedge core_clk_i) disable iff (rst_i)
      ((gpe_sts & ~$past(gpe_sts) & ~$past(gpe_ctl_q)) == '0);
  endproperty
  a_gpe_sts_mode: assert property (p_gpe_sts_mode) else $error("gpe status set outside gpe mode"); // see R12

  property p_gpio_plain;
    @(posedge core_clk_i) disable iff (rst_i)
      (!gpio_cfg_q[GPIO_ALT] ##1 !gpio_cfg_q[GPIO_ALT]) |-> (gpio7_o == $past(gpio_cfg_q[GPIO_LVL]));
  endproperty
  a_gpio_plain: assert property (p_gpio_plain) else $error("gpio7 follows gpe while not alternate"); // see R10

  property p_out_drops;
    @(posedge core_clk_i) disable iff (rst_i)
      (gp_event_out_o && ((gpe_sts & ~gpe_clr) == '0) && ((gpe_evt & gpe_ctl_q) == '0)) |=> !gp_event_out_o;
  endproperty
  a_out_drops: assert property (p_out_drops) else $error("shared output stays after full clear"); // see R16
endmodule // hes_top
`default_nettype wire

// >>> tb/hes_rc_model.sv
// Root complex sink model counting message requests per port
`default_nettype none
module hes_rc_model
  import hes_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [NP-1:0] msi_req_i,
  input wire logic [NP-1:0] pme_req_i,
  output int msi_cnt_o [NP],
  output int pme_cnt_o [NP]
);
  // One cycle per message, so a stuck request inflates the count
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < NP; i++) begin
      if (rst_i) begin
        msi_cnt_o[i] <= 0;
        pme_cnt_o[i] <= 0;
      end else begin
        msi_cnt_o[i] <= msi_cnt_o[i] + int'(msi_req_i[i]);
        pme_cnt_o[i] <= pme_cnt_o[i] + int'(pme_req_i[i]);
      end
    end
  end
endmodule // hes_rc_model
`default_nettype wire

// >>> tb/hes_top_tb.sv
// Self-checking bench for hot-plug event signalling
`default_nettype none
module hes_top_tb
  import hes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic psel_i = 1'h0;
  logic penable_i = 1'h0;
  logic pwrite_i = 1'h0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, sw_d3hot_i = 1'h0, irqm = 1'h1;
  logic [NP-1:0][EVT_W-1:0] slot_evt_i = '0;
  logic [NP-1:0] init_access_i = '0, other_msi_i = '0, other_pme_i = '0, other_intx_i = '0;
  logic [NP-1:0] msi_req_o, pme_req_o, intx_o;
  logic gp_event_out_o, gpio7_o, gpio7_oe_o, irq_o;
  logic [31:0] rv, r;
  logic ev_err;
  int msi_cnt [NP], pme_cnt [NP];
  int exp_msi [NP] = '{default: 0};
  int exp_pme [NP] = '{default: 0};
  int fail_count = 0, checks = 0, cycles = 0, seed = 32'hc495;

  hes_top dut_u (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .slot_evt_i, .init_access_i, .sw_d3hot_i, .other_msi_i, .other_pme_i,
    .other_intx_i, .msi_req_o, .pme_req_o, .intx_o, .gp_event_out_o, .gpio7_o, .gpio7_oe_o, .irq_o);
  hes_rc_model rc_u (.core_clk_i, .rst_i, .msi_req_i(msi_req_o), .pme_req_i(pme_req_o),
    .msi_cnt_o(msi_cnt), .pme_cnt_o(pme_cnt));

  always #25 core_clk_i = ~core_clk_i;

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard, far above the roughly one thousand cycles the run needs
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  // Master waits for pready with no assumed latency; only the hang guard ends a wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge core_clk_i);
    psel_i <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge core_clk_i);
    penable_i <= 1'h1;
    do begin
      @(posedge core_clk_i);
    end while (pready_o !== 1'h1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'h1, a, d, x, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] x;
    logic e;
    apb(1'h0, a, 32'h0000_0000, x, e);
    check(x, exp, what);
  endtask

  task automatic clr(input int p);
    wr({4'(p), OFF_SLOT_STS}, 32'h0000_001F);
    wr(OFF_GPE_STS, 32'h0000_001F);
    wr(OFF_IRQ_STS, 32'h0000_001F);
  endtask

  task automatic fire(input int p, input int b);
    @(posedge core_clk_i);
    slot_evt_i[p][b] <= 1'h1;
    @(posedge core_clk_i);
    slot_evt_i[p][b] <= 1'h0;
    repeat (5) @(posedge core_clk_i);
    #1;
  endtask

  // Reference model of one event: set up, fire, compare, clear
  task automatic ev(input int p, input int b, input logic ien, input logic [4:0] msk, input logic [2:0] cfg,
                    input logic swd3, input logic gpe, input logic alt);
    logic q, d3, irq, wake, gev, m, x;
    q = !msk[b];
    d3 = cfg[2] | swd3;
    irq = q & ien & !gpe;
    wake = q & d3 & (b != EVT_CMD) & !gpe;
    gev = gpe & q & (ien | (d3 & (b != EVT_CMD)));
    m = irq & cfg[0];
    x = irq & !cfg[0] & !cfg[1];
    exp_msi[p] += m;
    exp_pme[p] += wake;
    wr({4'(p), OFF_SLOT_CTL}, {26'h0, ien, msk});
    wr({4'(p), OFF_PORT_CFG}, {29'h0, cfg});
    wr(OFF_GPE_CTL, 32'(gpe) << p);
    wr(OFF_GPIO_CFG, 32'(alt));
    sw_d3hot_i <= swd3;
    fire(p, b);
    check(msi_cnt[p], exp_msi[p], "msi count");
    check(pme_cnt[p], exp_pme[p], "pme count");
    check(intx_o[p], x, "intx level");
    check(gp_event_out_o, gev, "gpe out");
    check(gpio7_o, gev & alt, "gpio7");
    check(gpio7_oe_o, alt, "gpio7 oe");
    check(irq_o, (m | wake | gev) & irqm, "irq out");
    rd_chk({4'(p), OFF_SLOT_STS}, 32'(1 << b), "slot status");
    rd_chk(OFF_GPE_STS, 32'(gev) << p, "gpe status");
    clr(p);
    repeat (2) @(posedge core_clk_i);
    #1;
    check(gp_event_out_o | intx_o[p] | irq_o, 1'h0, "cleared");
    $display("event test port %0d bit %0d done", p, b);
  endtask

  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'h0;
    rd_chk(OFF_SLOT_CTL, 32'h0000_0000, "ctl reset");
    rd_chk(OFF_GPE_CTL, 32'h0000_0000, "gpe ctl reset");
    rd_chk(OFF_IRQ_MSK, 32'h0000_0000, "irq mask reset");
    apb(1'h0, 8'hFC, 32'h0000_0000, rv, ev_err);
    check({rv[30:0], ev_err}, 32'h0000_0001, "unmapped read");
    $display("reset test done");
    wr(OFF_IRQ_MSK, 32'h0000_001F);
    for (int b = 0; b < EVT_W; b++) begin
      ev(0, b, 1'h1, 5'h00, 3'h1, 1'h0, 1'h0, 1'h1);
    end
    ev(1, 0, 1'h1, 5'h00, 3'h0, 1'h0, 1'h0, 1'h0);
    ev(1, 1, 1'h1, 5'h00, 3'h2, 1'h0, 1'h0, 1'h0);
    ev(2, 3, 1'h0, 5'h00, 3'h1, 1'h0, 1'h0, 1'h0);
    ev(2, 0, 1'h0, 5'h00, 3'h4, 1'h0, 1'h0, 1'h0);
    ev(3, 1, 1'h1, 5'h00, 3'h1, 1'h1, 1'h0, 1'h0);
    ev(3, 4, 1'h1, 5'h00, 3'h5, 1'h0, 1'h0, 1'h0);
    ev(4, 2, 1'h1, 5'h04, 3'h5, 1'h1, 1'h0, 1'h0);
    ev(4, 3, 1'h1, 5'h00, 3'h1, 1'h0, 1'h1, 1'h1);
    ev(1, 2, 1'h0, 5'h00, 3'h4, 1'h0, 1'h1, 1'h0);
    irqm = 1'h0;
    wr(OFF_IRQ_MSK, 32'h0000_0000);
    ev(0, 0, 1'h1, 5'h00, 3'h1, 1'h0, 1'h0, 1'h0);
    irqm = 1'h1;
    wr(OFF_IRQ_MSK, 32'h0000_001F);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      ev(int'(r[7:0] % NP), int'(r[15:8] % EVT_W), r[16], r[21:17], r[24:22], r[25], r[26], r[27]);
    end
    // Second event without a clear must not re-send
    wr({4'(1), OFF_SLOT_CTL}, 32'h0000_0020);
    wr({4'(1), OFF_PORT_CFG}, 32'h0000_0001);
    wr(OFF_GPE_CTL, 32'h0000_0000);
    sw_d3hot_i <= 1'h0;
    fire(1, EVT_BTN);
    fire(1, EVT_BTN);
    exp_msi[1]++;
    check(msi_cnt[1], exp_msi[1], "level-like msi");
    clr(1);
    $display("repeat event test done");
    // Initial expander access hides latch and presence changes only
    wr({4'(2), OFF_SLOT_CTL}, 32'h0000_001F);
    init_access_i[2] <= 1'h1;
    fire(2, EVT_LATCH);
    fire(2, EVT_PRES);
    fire(2, EVT_BTN);
    rd_chk({4'(2), OFF_SLOT_STS}, 32'h0000_0001, "init suppress");
    init_access_i <= '0;
    clr(2);
    $display("init access test done");
    // Plain level and enable drive the pin while not alternate
    wr(OFF_GPIO_CFG, 32'h0000_0006);
    repeat (2) @(posedge core_clk_i);
    #1;
    check(gpio7_o, 1'h1, "gpio7 plain level");
    check(gpio7_oe_o, 1'h1, "gpio7 plain oe");
    wr(OFF_GPIO_CFG, 32'h0000_0000);
    repeat (2) @(posedge core_clk_i);
    #1;
    check(gpio7_o, 1'h0, "gpio7 plain low");
    check(gpio7_oe_o, 1'h0, "gpio7 released");
    $display("gpio plain test done");
    // Non hot-plug sources still pass in GPE mode
    wr(OFF_GPE_CTL, 32'h0000_001F);
    other_msi_i[3] <= 1'h1;
    other_pme_i[3] <= 1'h1;
    other_intx_i[3] <= 1'h1;
    @(posedge core_clk_i);
    other_msi_i <= '0;
    other_pme_i <= '0;
    repeat (3) @(posedge core_clk_i);
    #1;
    exp_msi[3]++;
    exp_pme[3]++;
    check(msi_cnt[3], exp_msi[3], "other msi");
    check(pme_cnt[3], exp_pme[3], "other pme");
    check(intx_o[3], 1'h1, "other intx");
    other_intx_i <= '0;
    $display("other source test done");
    conclude();
  end
endmodule // hes_top_tb
`default_nettype wire
